// ==== design/irq_pkg.sv ====
// Purpose : Shared constants for the interrupt priority and wake block
// Assumes : Request sources are level flags held by their peripherals
// Notes   : Vector index 0 is the smallest vector address
//
// Overview of operation
// - Three nesting levels; refuse requests at or below serviced level
// - Highest pending level wins: highest over high over low
// - Equal levels: the smallest vector address wins
// - Twenty-seven sources merge onto ten vector addresses
// - Ext two, timer zero low, ext four share 00013H, high or low
// - Ext three, ext five, both base timer requests share 0001BH
// - Timer one low, timer one high, ext seven share 0002BH
// - Sync serial zero and both async receive requests share 00033H
// - Serial one and both async transmit requests share 0003BH
// - Port zero, timers four and five, PWM requests share 0004BH
// - Halt keeps peripherals running; ends on reset or accepted request
// - Both hold modes wake on active ext pins 0,1,2,4,5 or reset pin low
// - Both hold modes wake when a port zero source is established
// - Only crystal hold also wakes on an established base timer source
package irq_pkg;
    //------------------------------------------------------------------
    // Sizes and level codes
    //------------------------------------------------------------------
    localparam int       NUM_SRC  = 27;
    localparam int       NUM_VEC  = 10;
    localparam int       ADDR_W   = 20;
    localparam int       NUM_PIN  = 8;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_LOW  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_TOP  = 2'h3;

    //------------------------------------------------------------------
    // Vector map: address, upper level and member sources
    //------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] VEC_ADDR [NUM_VEC] = '{
        20'h00003, 20'h0000b, 20'h00013, 20'h0001b, 20'h00023,
        20'h0002b, 20'h00033, 20'h0003b, 20'h00043, 20'h0004b};
    localparam logic [1:0] VEC_UPPER [NUM_VEC] = '{
        LVL_TOP, LVL_TOP, LVL_HIGH, LVL_HIGH, LVL_HIGH,
        LVL_HIGH, LVL_HIGH, LVL_HIGH, LVL_HIGH, LVL_HIGH};
    localparam logic [NUM_SRC-1:0] VEC_SRC_MASK [NUM_VEC] = '{
        27'h0000001,
        27'h0000002,
        27'h000001c,
        27'h00001e0,
        27'h0000600,
        27'h0003800,
        27'h001c000,
        27'h00e0000,
        27'h0700000,
        27'h7800000};

    //------------------------------------------------------------------
    // Wake sources
    //------------------------------------------------------------------
    localparam logic [NUM_PIN-1:0] WAKE_PIN_MASK  = 8'h37;
    localparam logic [NUM_SRC-1:0] PORT_ZERO_MASK = 27'h0800000;
    localparam logic [NUM_SRC-1:0] BASE_TMR_MASK  = 27'h0000180;

    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_HALT  = 4'h2,
        ST_HOLD  = 4'h4,
        ST_XHOLD = 4'h8
    } stby_t;
endpackage : irq_pkg

// ==== design/irq_priority_wake.sv ====
// Purpose : Interrupt priority, vectoring, nesting and standby wake
// Assumes : Sources hold their flags until the handler clears them
// Notes   : Core acknowledges a request with IRQ_ACK, returns with IRQ_RETI
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_wake_ctrl
    import irq_pkg::*;
(
    input  wire logic               CLK,
    input  wire logic               SRST,
    input  wire logic [NUM_SRC-1:0] SRC_REQ,
    input  wire logic [NUM_VEC-1:0] VEC_LVL_SEL,
    input  wire logic               IRQ_ACK,
    input  wire logic               IRQ_RETI,
    output var  logic               IRQ_REQ,
    output var  logic [ADDR_W-1:0]  IRQ_VECTOR,
    output var  logic [1:0]         IRQ_LEVEL,
    output var  logic [1:0]         SERVICE_LEVEL,
    input  wire logic [NUM_PIN-1:0] EXT_PIN,
    input  wire logic [NUM_PIN-1:0] EXT_PIN_ACT,
    input  wire logic               RESET_PIN_N,
    input  wire logic               HALT_ENTER,
    input  wire logic               HOLD_ENTER,
    input  wire logic               XHOLD_ENTER,
    output var  logic               CPU_RUN,
    output var  logic               PERIPH_RUN,
    output var  logic               BASE_TIMER_RUN,
    output var  logic               WAKE
);
    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    logic [1:0]         vlev [NUM_VEC];
    logic [1:0]         best_lvl;
    logic [3:0]         best_idx;
    logic [1:0]         cur_lvl;
    logic               accepted;
    logic               req_r;
    logic               req_nxt;
    logic [ADDR_W-1:0]  vector_r;
    logic [1:0]         level_r;
    logic [2:0]         in_svc_r;
    logic [2:0]         in_svc_nxt;
    stby_t              st_r;
    stby_t              st_nxt;
    logic               wake_r;
    logic [NUM_PIN-1:0] pin_s;
    logic               rst_pin_s;
    logic               pin_wake;
    logic               hold_wake;

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    pin_sync #(.W(NUM_PIN), .RST_VAL('0)) u_ext_sync (
        .clk     (CLK),
        .srst    (SRST),
        .pin_in  (EXT_PIN),
        .pin_out (pin_s)
    );

    pin_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
        .clk     (CLK),
        .srst    (SRST),
        .pin_in  (RESET_PIN_N),
        .pin_out (rst_pin_s)
    );

    //------------------------------------------------------------------
    // Vector merge and per-vector level
    //------------------------------------------------------------------
    // Shared vectors: any member source raises the vector
    always_comb begin
        for (int i = 0; i < NUM_VEC; i++) begin
            if ((SRC_REQ & VEC_SRC_MASK[i]) == '0) begin
                vlev[i] = LVL_NONE;
            end else if (VEC_LVL_SEL[i]) begin
                vlev[i] = VEC_UPPER[i];
            end else begin
                vlev[i] = LVL_LOW;
            end
        end
    end

    // Descending scan with >= leaves the smallest index on a tie
    always_comb begin
        best_lvl = LVL_NONE;
        best_idx = 4'h0;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (vlev[i] != LVL_NONE && vlev[i] >= best_lvl) begin
                best_lvl = vlev[i];
                best_idx = i[3:0];
            end
        end
    end

    //------------------------------------------------------------------
    // Nesting and acceptance
    //------------------------------------------------------------------
    // Serviced level is the highest level still marked in service
    always_comb begin
        if (in_svc_r[2]) begin
            cur_lvl = LVL_TOP;
        end else if (in_svc_r[1]) begin
            cur_lvl = LVL_HIGH;
        end else if (in_svc_r[0]) begin
            cur_lvl = LVL_LOW;
        end else begin
            cur_lvl = LVL_NONE;
        end
    end

    // Equal or lower levels are refused outright
    assign accepted = (best_lvl > cur_lvl);

    // Return drops the top level; acknowledge pushes the granted one
    always_comb begin
        in_svc_nxt = in_svc_r;
        if (IRQ_RETI) begin
            if (in_svc_r[2]) begin
                in_svc_nxt[2] = 1'b0;
            end else if (in_svc_r[1]) begin
                in_svc_nxt[1] = 1'b0;
            end else begin
                in_svc_nxt[0] = 1'b0;
            end
        end
        if (IRQ_ACK && req_r) begin
            in_svc_nxt[level_r - LVL_LOW] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            in_svc_r <= 3'h0;
        end else begin
            in_svc_r <= in_svc_nxt;
        end
    end

    // Ack cycle masks the request so a stale grant never repeats
    assign req_nxt = accepted && !IRQ_ACK &&
                     (st_r == ST_RUN || st_r == ST_HALT);

    // Request, vector and level come from flops
    always_ff @(posedge CLK) begin
        if (SRST) begin
            req_r    <= 1'b0;
            vector_r <= '0;
            level_r  <= LVL_NONE;
        end else begin
            req_r    <= req_nxt;
            vector_r <= VEC_ADDR[best_idx];
            level_r  <= best_lvl;
        end
    end

    //------------------------------------------------------------------
    // Standby control
    //------------------------------------------------------------------
    // Only the pins able to end hold are looked at
    assign pin_wake  = |(~(pin_s ^ EXT_PIN_ACT) & WAKE_PIN_MASK);
    assign hold_wake = pin_wake || !rst_pin_s ||
                       ((SRC_REQ & PORT_ZERO_MASK) != '0);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN: begin
                if (HALT_ENTER) begin
                    st_nxt = ST_HALT;
                end else if (HOLD_ENTER) begin
                    st_nxt = ST_HOLD;
                end else if (XHOLD_ENTER) begin
                    st_nxt = ST_XHOLD;
                end
            end
            ST_HALT: begin
                if (accepted) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (hold_wake) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_XHOLD: begin
                if (hold_wake || (SRC_REQ & BASE_TMR_MASK) != '0) begin
                    st_nxt = ST_RUN;
                end
            end
            default: st_nxt = ST_RUN;
        endcase
    end

    // System reset also ends every standby mode
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r   <= ST_RUN;
            wake_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            wake_r <= (st_r != ST_RUN) && (st_nxt == ST_RUN);
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign IRQ_REQ        = req_r;
    assign IRQ_VECTOR     = vector_r;
    assign IRQ_LEVEL      = level_r;
    assign SERVICE_LEVEL  = cur_lvl;
    assign CPU_RUN        = (st_r == ST_RUN);
    assign PERIPH_RUN     = (st_r == ST_RUN) || (st_r == ST_HALT);
    assign BASE_TIMER_RUN = (st_r != ST_HOLD);
    assign WAKE           = wake_r;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_grant_ack;
        IRQ_REQ && IRQ_ACK && !IRQ_RETI;
    endsequence

    property p_refuse_low;
        IRQ_REQ |-> IRQ_LEVEL > SERVICE_LEVEL;
    endproperty
    a_refuse_low: assert property (p_refuse_low)
        else $error("Request at or below serviced level");

    property p_push_level;
        s_grant_ack |=> SERVICE_LEVEL == $past(IRQ_LEVEL) && !IRQ_REQ;
    endproperty
    a_push_level: assert property (p_push_level)
        else $error("Acknowledge did not raise serviced level");

    property p_top_wins;
        IRQ_REQ && $past(vlev[0] == LVL_TOP) |-> IRQ_LEVEL == LVL_TOP;
    endproperty
    a_top_wins: assert property (p_top_wins)
        else $error("Highest level pending but not granted");

    property p_small_vec;
        IRQ_REQ && $past(vlev[0] != LVL_NONE && vlev[0] == best_lvl)
            |-> IRQ_VECTOR == VEC_ADDR[0];
    endproperty
    a_small_vec: assert property (p_small_vec)
        else $error("Tie not resolved to smallest vector");

    property p_shared_two;
        IRQ_REQ && IRQ_VECTOR == VEC_ADDR[2] && IRQ_LEVEL == LVL_HIGH
            |-> $past((SRC_REQ & VEC_SRC_MASK[2]) != '0 && VEC_LVL_SEL[2]);
    endproperty
    a_shared_two: assert property (p_shared_two)
        else $error("Vector 00013H granted without member source");

    property p_halt_wake;
        st_r == ST_HALT && accepted |=> CPU_RUN ##1 WAKE == 1'b0;
    endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("Halt not ended by accepted request");

    property p_hold_rst_pin;
        st_r == ST_HOLD && !rst_pin_s |=> CPU_RUN && WAKE;
    endproperty
    a_hold_rst_pin: assert property (p_hold_rst_pin)
        else $error("Hold not ended by reset pin");

    property p_port_zero;
        (st_r == ST_HOLD || st_r == ST_XHOLD) &&
            (SRC_REQ & PORT_ZERO_MASK) != '0 |=> CPU_RUN;
    endproperty
    a_port_zero: assert property (p_port_zero)
        else $error("Port zero source did not end hold");

    property p_bt_only_xhold;
        st_r == ST_HOLD && !hold_wake |=> st_r == ST_HOLD && !PERIPH_RUN;
    endproperty
    a_bt_only_xhold: assert property (p_bt_only_xhold)
        else $error("Hold left without a hold wake source");
endmodule : interrupt_priority_wake_ctrl
`default_nettype wire

// ==== design/pin_sync.sv ====
// Purpose : Three-flop pin synchroniser with agreement filter
// Assumes : Input is asynchronous to clk
// Notes   : Output moves only when the second and third flops agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] pin_out
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;

    // First flop feeds only the second, to keep metastability contained
    always_ff @(posedge clk) begin
        if (srst) begin
            ff1_r <= RST_VAL;
            ff2_r <= RST_VAL;
            ff3_r <= RST_VAL;
        end else begin
            ff1_r <= pin_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // Per-bit agreement filter rejects single-cycle glitches
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (ff2_r[i] == ff3_r[i]) begin
                    pin_out[i] <= ff3_r[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// ==== testbench/core_model.sv ====
// Purpose: Core side model that takes granted requests
// Assumes: Bench gates taking with take_en and asks for returns
// Notes  : Never acks two cycles running, as the real core
`timescale 1ns/1ns
`default_nettype none
module core_model
    import irq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              take_en,
    input  wire logic              reti_cmd,
    input  wire logic              irq_req,
    input  wire logic [ADDR_W-1:0] irq_vector,
    output var  logic              irq_ack,
    output var  logic              irq_reti,
    output var  logic [ADDR_W-1:0] got_vec
);
    // ----
    // Ack
    // ----
    // Driven off the sampling edge so the block sees a clean pulse
    always @(negedge clk) begin
        irq_ack <= take_en && irq_req && !irq_ack;
    end
    // Return is commanded by the bench
    assign irq_reti = reti_cmd;
    // Vector as the core latched it
    always @(posedge clk) begin
        if (irq_ack) begin
            got_vec <= irq_vector;
        end
    end
endmodule : core_model
`default_nettype wire

// ==== testbench/interrupt_priority_wake_ctrl_tb.sv ====
// Purpose: Self-checking bench for priority, nesting and wake
// Assumes: Inputs change at the falling clock edge
// Notes  : Pins idle at the inverse of their active level
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_wake_ctrl_tb;
    import irq_pkg::*;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic [26:0]       src = '0;
    logic [9:0]        sel = '0;
    logic [7:0]        ext_act = 8'ha5;
    logic [7:0]        ext_pin = 8'h5a;
    logic              rst_n = 1'b1;
    logic              halt_e = 1'b0;
    logic              hold_e = 1'b0;
    logic              xhold_e = 1'b0;
    logic              take_en = 1'b0;
    logic              reti_cmd = 1'b0;
    logic              ack, reti, irq_req, cpu_run, periph, btr, wake;
    logic [19:0]       irq_vector, got_vec;
    logic [1:0]        irq_level, svc;
    int                checks = 0;
    int                n_mismatch = 0;
    // ----
    // Clock and parts
    // ----
    always #25 clk = ~clk;
    interrupt_priority_wake_ctrl i_interrupt_priority_wake_ctrl (
        .CLK(clk), .SRST(srst), .SRC_REQ(src), .VEC_LVL_SEL(sel),
        .IRQ_ACK(ack), .IRQ_RETI(reti), .IRQ_REQ(irq_req),
        .IRQ_VECTOR(irq_vector), .IRQ_LEVEL(irq_level),
        .SERVICE_LEVEL(svc), .EXT_PIN(ext_pin), .EXT_PIN_ACT(ext_act),
        .RESET_PIN_N(rst_n), .HALT_ENTER(halt_e), .HOLD_ENTER(hold_e),
        .XHOLD_ENTER(xhold_e), .CPU_RUN(cpu_run), .PERIPH_RUN(periph),
        .BASE_TIMER_RUN(btr), .WAKE(wake));
    core_model i_core_model (
        .clk(clk), .take_en(take_en), .reti_cmd(reti_cmd),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(ack),
        .irq_reti(reti), .got_vec(got_vec));
    // ----
    // Helpers
    // ----
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic cmp_val(input string w, input logic [19:0] e,
                           input logic [19:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", w, e, g);
        end
    endtask : cmp_val
    task automatic cmp_bit(input string w, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %b got %b", w, e, g);
        end
    endtask : cmp_bit
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Bounded wait for a request or for the core to run again
    task automatic wait_on(input bit wk);
        int n;
        n = 0;
        while ((wk ? cpu_run : irq_req) !== 1'b1) begin
            if (n == 40) begin
                n_mismatch++;
                $display("[FAIL] wait exp 1 got 0");
                close_out();
            end
            tick(1);
            n++;
        end
    endtask : wait_on
    task automatic quiet(input int n, input bit wk);
        repeat (n) begin
            tick(1);
            cmp_bit("quiet", 1'b0, wk ? cpu_run : irq_req);
        end
    endtask : quiet
    task automatic pulse_reti;
        reti_cmd = 1'b1;
        tick(1);
        reti_cmd = 1'b0;
        tick(1);
    endtask : pulse_reti
    task automatic enter(input int m);
        {halt_e, hold_e, xhold_e} = 3'b100 >> m;
        tick(1);
        {halt_e, hold_e, xhold_e} = 3'b000;
    endtask : enter
    // ----
    // Scenarios
    // ----
    // Every source alone: vector, level, push and pop
    task automatic t_map;
        int vi [27] = '{0,1,2,2,2,3,3,3,3,4,4,5,5,5,6,6,6,7,7,7,8,8,8,
                        9,9,9,9};
        logic [19:0] ev;
        logic [19:0] el;
        sel = 10'h3ff;
        take_en = 1'b1;
        for (int s = 0; s < 27; s++) begin
            ev = 20'h3 + 20'(vi[s] * 8);
            el = (vi[s] < 2) ? 20'h3 : 20'h2;
            src = 27'h1 << s;
            wait_on(1'b0);
            cmp_val("vec", ev, irq_vector);
            cmp_val("lvl", el, 20'(irq_level));
            tick(2);
            cmp_val("took", ev, got_vec);
            cmp_val("svc", 20'(irq_level), 20'(svc));
            cmp_val("svc", el, 20'(svc));
            src = '0;
            pulse_reti();
            cmp_val("svc idle", 20'h0, 20'(svc));
        end
        $display("test map done");
    endtask : t_map
    task automatic t_prio;
        take_en = 1'b0;
        sel = 10'h200;
        src = 27'h4000001;
        wait_on(1'b0);
        tick(1);
        cmp_val("high over low", 20'h4b, irq_vector);
        sel = 10'h000;
        src = 27'h4004020;
        tick(2);
        cmp_val("smallest", 20'h1b, irq_vector);
        src = '0;
        tick(2);
        $display("test prio done");
    endtask : t_prio
    task automatic t_nest;
        sel = 10'h212;
        take_en = 1'b1;
        src = 27'h4000000;
        wait_on(1'b0);
        tick(2);
        take_en = 1'b0;
        src = 27'h4000204;
        quiet(6, 1'b0);
        src = 27'h4000206;
        wait_on(1'b0);
        cmp_val("nested", 20'h0000b, irq_vector);
        take_en = 1'b1;
        tick(2);
        take_en = 1'b0;
        cmp_val("svc top", 20'h3, 20'(svc));
        src = 27'h0000204;
        pulse_reti();
        cmp_val("svc pop", 20'h2, 20'(svc));
        cmp_bit("refused", 1'b0, irq_req);
        pulse_reti();
        tick(1);
        cmp_val("after pop", 20'h23, irq_vector);
        src = '0;
        tick(2);
        $display("test nest done");
    endtask : t_nest
    task automatic t_halt;
        sel = 10'h3ff;
        enter(0);
        cmp_bit("halt cpu", 1'b0, cpu_run);
        cmp_bit("halt periph", 1'b1, periph);
        src = 27'h0020000;
        wait_on(1'b1);
        cmp_bit("halt wake", 1'b1, wake);
        src = '0;
        tick(2);
        $display("test halt done");
    endtask : t_halt
    task automatic t_hold;
        enter(1);
        cmp_bit("hold periph", 1'b0, periph);
        cmp_bit("hold btr", 1'b0, btr);
        src = 27'h0000080;
        quiet(6, 1'b1);
        src = 27'h0800080;
        wait_on(1'b1);
        cmp_bit("p0 wake", 1'b1, wake);
        tick(1);
        cmp_bit("wake pulse", 1'b0, wake);
        src = '0;
        for (int k = 0; k < 8; k++) begin
            enter(1);
            ext_pin[k] = ext_act[k];
            if (((8'h37 >> k) & 8'h1) == 8'h1) begin
                wait_on(1'b1);
            end else begin
                quiet(8, 1'b1);
                rst_n = 1'b0;
                wait_on(1'b1);
            end
            cmp_bit("pin wake", 1'b1, wake);
            ext_pin = ~ext_act;
            rst_n = 1'b1;
            tick(6);
        end
        $display("test hold done");
    endtask : t_hold
    task automatic t_xhold;
        enter(2);
        cmp_bit("xhold btr", 1'b1, btr);
        cmp_bit("xhold periph", 1'b0, periph);
        src = 27'h0000100;
        wait_on(1'b1);
        cmp_bit("bt wake", 1'b1, wake);
        src = '0;
        tick(2);
        enter(2);
        src = 27'h0800000;
        wait_on(1'b1);
        cmp_bit("xp0 wake", 1'b1, wake);
        src = '0;
        tick(2);
        $display("test xhold done");
    endtask : t_xhold
    // Reset in mid-run ends halt and clears the nesting state
    task automatic t_rst;
        sel = 10'h3ff;
        take_en = 1'b1;
        src = 27'h0000001;
        wait_on(1'b0);
        tick(2);
        take_en = 1'b0;
        src = '0;
        cmp_val("pre svc", 20'h3, 20'(svc));
        enter(0);
        cmp_bit("pre cpu", 1'b0, cpu_run);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        cmp_bit("rst cpu", 1'b1, cpu_run);
        cmp_val("rst svc2", 20'h0, 20'(svc));
        cmp_bit("rst wake", 1'b0, wake);
        tick(2);
        cmp_bit("rst req2", 1'b0, irq_req);
        $display("test reset done");
    endtask : t_rst
    // ----
    // Main sequence
    // ----
    initial begin
        tick(8);
        srst = 1'b0;
        cmp_bit("rst run", 1'b1, cpu_run);
        cmp_bit("rst req", 1'b0, irq_req);
        cmp_val("rst svc", 20'h0, 20'(svc));
        t_map();
        t_prio();
        t_nest();
        t_halt();
        t_hold();
        t_xhold();
        t_rst();
        close_out();
    end
endmodule : interrupt_priority_wake_ctrl_tb
`default_nettype wire
